// >>> verilog/diag_pkg.sv
/*
 Diagnostic register bank constants: offsets, tag nibbles, bit positions,
 limits and the packed event carrier.
 Assumes a 250 MHz core clock.
*/
`default_nettype none
package diag_pkg;
    // ----------------------------------------------------------------
    // Register offsets (byte address of the high byte)
    // ----------------------------------------------------------------
    localparam logic [7:0] ERROR_OFFSET = 8'h24;
    localparam logic [7:0] CAUTION_OFFSET = 8'h26;
    localparam logic [7:0] TEMP_OFFSET = 8'h28;
    localparam logic [7:0] FIELD_OFFSET = 8'h2A;
    localparam logic [5:0] SPECIAL_TURNS_RESET = 6'h1E;
    // ----------------------------------------------------------------
    // Tag nibbles
    // ----------------------------------------------------------------
    localparam logic [3:0] ERROR_TAG = 4'hA;
    localparam logic [3:0] CAUTION_TAG = 4'hB;
    localparam logic [3:0] TEMP_TAG = 4'hF;
    localparam logic [3:0] FIELD_TAG = 4'hE;
    // ----------------------------------------------------------------
    // Bit positions
    // ----------------------------------------------------------------
    localparam int ERR_RESET_BIT = 0;
    localparam int ERR_WEAK_BIT = 1;
    localparam int ERR_ASUPPLY_BIT = 2;
    localparam int ERR_SUMMARY_BIT = 11;
    localparam int ANY_FAULT_BIT = 14;
    localparam int CAU_LINK_BIT = 11;
    localparam int CAU_CRC_BIT = 10;
    localparam int CAU_SLOPE_BIT = 8;
    localparam int CAU_LONGCMD_BIT = 7;
    localparam int CAU_TEMP_BIT = 6;
    localparam int CAU_EEPROM_BIT = 5;
    localparam int CAU_CLIP_BIT = 4;
    localparam int CAU_SLEEP_BIT = 3;
    localparam int CAU_OVERLAP_BIT = 2;
    localparam int CAU_STRONG_BIT = 1;
    localparam int CAU_TURNS_BIT = 0;
    localparam logic [11:0] CAU_IMPL_MASK = 12'hDFF;
    // ----------------------------------------------------------------
    // Limits and timing
    // ----------------------------------------------------------------
    localparam logic signed [11:0] TEMP_MIN = -12'sd680;   // -60 C rel 25 C
    localparam logic signed [11:0] TEMP_MAX = 12'sd1240;   // 180 C rel 25 C
    localparam logic [11:0] WEAK_LIMIT_DEF = 12'd200;
    localparam logic [11:0] STRONG_LIMIT_DEF = 12'd1200;
    localparam logic [11:0] ANGLE_JUMP = 12'd1536;         // 135 deg of 4096
    localparam logic signed [11:0] TURNS_MAX_HALF = 12'sd511;
    localparam logic signed [11:0] TURNS_MIN_HALF = -12'sd512;
    localparam logic signed [11:0] TURNS_MAX_EIGHTH = 12'sd2047;
    localparam logic signed [11:0] TURNS_MIN_EIGHTH = -12'sd2048;
    localparam int CLOCK_MHZ = 250;
    localparam int FIELD_PERIOD_US = 128;
    localparam int FIELD_PERIOD_CYC = FIELD_PERIOD_US * CLOCK_MHZ;

    // Hardware event strobes and levels from the sensor core
    typedef struct packed {
        logic asupply_low;
        logic link_fault;
        logic crc_bad;
        logic slope_active;
        logic long_cmd_fail;
        logic eeprom_corrected;
        logic clipping;
        logic long_access_overlap;
    } event_type;
endpackage : diag_pkg
`default_nettype wire

// >>> verilog/sample_hold.sv
/*
 Periodic sample-and-hold for a measured word; refreshed on an enable.
 Assumes value_in is synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_hold #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Data
    input wire logic load,
    input wire logic [WIDTH-1:0] value_in,
    output logic [WIDTH-1:0] value_q
);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= '0;
        end else if (load) begin
            value_q <= value_in;
        end
    end
endmodule : sample_hold
`default_nettype wire

// >>> verilog/diag_regs.sv
/*
 Diagnostic and measurement register bank: error low flags, latched
 caution flags, die temperature and field strength, read by address.
 Assumes core-side inputs are synchronous to clock except the supply
 comparator, which comes from an analog pin.
*/
// Contract
// - Analog supply low sets bit 2, persists
// - Field below weak limit sets bit 1
// - Power-on or hard reset sets bit 0
// - Caution bits latch until cleared
// - Tag nibbles 1011, 1111, 1110 on top
// - Bad packet discarded, sets bit 11
// - Bad CRC with checking sets bit 10
// - Slope limiting active sets bit 8
// - Failed long command sets bit 7
// - Temperature out of range sets 6, saturates
// - Corrected EEPROM error sets bit 5
// - Any clipping sets bit 4
// - Sleep angle jump over 135 sets 3
// - Overlapping long access sets bit 2
// - Field above strong limit sets bit 1
// - Turns beyond range sets bit 0
// - Turns overflow clears only by special
// - Temperature signed eighths relative 25 C
// - Summary bit follows unmasked cautions
// - Any fault flag follows unmasked flags
`timescale 1ns/1ps
`default_nettype none
module diag_regs #(
    parameter int FIELD_PERIOD = diag_pkg::FIELD_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic error_clear,
    input wire logic caution_clear,
    input wire logic [5:0] special_cmd,
    input wire logic special_go,
    output logic [15:0] read_data_q,
    output logic read_valid_q,
    // Sensor core
    input wire logic asupply_low_pin,
    input wire diag_pkg::event_type events,
    input wire logic [11:0] field_gauss,
    input wire logic [11:0] weak_field_limit,
    input wire logic [11:0] strong_field_limit,
    input wire logic signed [12:0] temp_raw,
    input wire logic low_power_state,
    input wire logic awake_sample,
    input wire logic [11:0] awake_angle,
    input wire logic eighth_turns,
    input wire logic signed [12:0] turns_raw,
    input wire logic [15:0] flag_mask,
    // Status
    output logic any_fault_flag_q,
    output logic [11:0] die_temperature_q
);
    logic asupply_meta_q, asupply_sync_q;
    logic [2:0] error_low_q;
    logic [11:0] caution_q, caution_set;
    logic [11:0] last_angle_q, angle_delta;
    logic angle_seen_q;
    logic [11:0] field_held;
    logic [$clog2(FIELD_PERIOD+1)-1:0] field_cnt_q;
    logic field_tick_q;
    logic signed [11:0] temp_sat;
    logic temp_out;
    logic turns_over;
    logic summary;
    logic [15:0] error_word, caution_word, temp_word, field_word;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            asupply_meta_q <= 1'b0;
            asupply_sync_q <= 1'b0;
        end else begin
            asupply_meta_q <= asupply_low_pin;
            asupply_sync_q <= asupply_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Condition detection
    // ----------------------------------------------------------------
    always_comb begin
        temp_out = (temp_raw < 13'(diag_pkg::TEMP_MIN))
            || (temp_raw > 13'(diag_pkg::TEMP_MAX));
        if (temp_raw < 13'(diag_pkg::TEMP_MIN)) begin
            temp_sat = diag_pkg::TEMP_MIN;
        end else if (temp_raw > 13'(diag_pkg::TEMP_MAX)) begin
            temp_sat = diag_pkg::TEMP_MAX;
        end else begin
            temp_sat = temp_raw[11:0];
        end
        if (eighth_turns) begin
            turns_over = (turns_raw > 13'(diag_pkg::TURNS_MAX_EIGHTH))
                || (turns_raw < 13'(diag_pkg::TURNS_MIN_EIGHTH));
        end else begin
            turns_over = (turns_raw > 13'(diag_pkg::TURNS_MAX_HALF))
                || (turns_raw < 13'(diag_pkg::TURNS_MIN_HALF));
        end
        angle_delta = awake_angle - last_angle_q;
        if (angle_delta[11]) begin
            angle_delta = 12'h000 - angle_delta;
        end
    end

    always_comb begin
        caution_set = '0;
        caution_set[diag_pkg::CAU_LINK_BIT] = events.link_fault;
        caution_set[diag_pkg::CAU_CRC_BIT] = events.crc_bad;
        caution_set[diag_pkg::CAU_SLOPE_BIT] = events.slope_active;
        caution_set[diag_pkg::CAU_LONGCMD_BIT] = events.long_cmd_fail;
        caution_set[diag_pkg::CAU_TEMP_BIT] = temp_out;
        caution_set[diag_pkg::CAU_EEPROM_BIT] = events.eeprom_corrected;
        caution_set[diag_pkg::CAU_CLIP_BIT] = events.clipping;
        caution_set[diag_pkg::CAU_SLEEP_BIT] = low_power_state && awake_sample
            && angle_seen_q && (angle_delta > diag_pkg::ANGLE_JUMP);
        caution_set[diag_pkg::CAU_OVERLAP_BIT] = events.long_access_overlap;
        caution_set[diag_pkg::CAU_STRONG_BIT] = field_gauss > strong_field_limit;
        caution_set[diag_pkg::CAU_TURNS_BIT] = turns_over;
    end

    // ----------------------------------------------------------------
    // Sleep angle tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last_angle_q <= '0;
            angle_seen_q <= 1'b0;
        end else if (!low_power_state) begin
            angle_seen_q <= 1'b0;
        end else if (awake_sample) begin
            last_angle_q <= awake_angle;
            angle_seen_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Latched flags; set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            error_low_q <= '0;
            error_low_q[diag_pkg::ERR_RESET_BIT] <= 1'b1;
        end else begin
            error_low_q[diag_pkg::ERR_RESET_BIT] <=
                !error_clear && error_low_q[diag_pkg::ERR_RESET_BIT];
            error_low_q[diag_pkg::ERR_WEAK_BIT] <= (field_gauss < weak_field_limit)
                || (!error_clear && error_low_q[diag_pkg::ERR_WEAK_BIT]);
            error_low_q[diag_pkg::ERR_ASUPPLY_BIT] <= asupply_sync_q
                || (!error_clear && error_low_q[diag_pkg::ERR_ASUPPLY_BIT]);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            caution_q <= '0;
        end else begin
            // Turns overflow ignores the ordinary clear
            caution_q <= (caution_set | (caution_q & ~(caution_clear ? 12'hFFE : 12'h000)))
                & diag_pkg::CAU_IMPL_MASK;
            if (special_go && special_cmd == diag_pkg::SPECIAL_TURNS_RESET
                    && !turns_over) begin
                caution_q[diag_pkg::CAU_TURNS_BIT] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Measurement refresh
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            field_cnt_q <= '0;
            field_tick_q <= 1'b0;
        end else if (field_cnt_q == ($bits(field_cnt_q))'(FIELD_PERIOD - 1)) begin
            field_cnt_q <= '0;
            field_tick_q <= 1'b1;
        end else begin
            field_cnt_q <= field_cnt_q + 1'b1;
            field_tick_q <= 1'b0;
        end
    end

    sample_hold #(
        .WIDTH(12)
    ) u_field (
        .clock(clock),
        .rst_n(rst_n),
        .load(field_tick_q),
        .value_in(field_gauss),
        .value_q(field_held)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            die_temperature_q <= '0;
        end else begin
            die_temperature_q <= temp_sat;
        end
    end

    // ----------------------------------------------------------------
    // Read words and summary
    // ----------------------------------------------------------------
    always_comb begin
        summary = |(caution_q & ~flag_mask[11:0]);
        error_word = {diag_pkg::ERROR_TAG, summary, 8'h00, error_low_q[2:0]};
        error_word[diag_pkg::ERR_SUMMARY_BIT] = summary;
        caution_word = {diag_pkg::CAUTION_TAG, caution_q};
        temp_word = {diag_pkg::TEMP_TAG, die_temperature_q};
        field_word = {diag_pkg::FIELD_TAG, field_held};
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            any_fault_flag_q <= 1'b0;
        end else begin
            any_fault_flag_q <= summary || |(error_low_q[2:0] & ~flag_mask[14:12]);
        end
    end

    // Writes are not decoded: the bank is read-only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            read_data_q <= '0;
            read_valid_q <= 1'b0;
        end else begin
            read_valid_q <= reg_read && !reg_write;
            if (reg_read && !reg_write) begin
                case (reg_addr)
                    diag_pkg::ERROR_OFFSET: read_data_q <= error_word;
                    diag_pkg::CAUTION_OFFSET: read_data_q <= caution_word;
                    diag_pkg::TEMP_OFFSET: read_data_q <= temp_word;
                    diag_pkg::FIELD_OFFSET: read_data_q <= field_word;
                    default: read_data_q <= 16'h0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_caution_holds;
        @(posedge clock) disable iff (!rst_n)
        (caution_q[diag_pkg::CAU_LINK_BIT] && !caution_clear)
            |=> caution_q[diag_pkg::CAU_LINK_BIT];
    endproperty
    a_caution_holds: assert property (p_caution_holds)
        else $error("caution flag dropped without clear");

    property p_link_sets;
        @(posedge clock) disable iff (!rst_n)
        events.link_fault |=> caution_q[diag_pkg::CAU_LINK_BIT];
    endproperty
    a_link_sets: assert property (p_link_sets)
        else $error("link fault not latched");

    property p_asupply;
        @(posedge clock) disable iff (!rst_n)
        asupply_low_pin ##2 1 |=> error_low_q[diag_pkg::ERR_ASUPPLY_BIT];
    endproperty
    a_asupply: assert property (p_asupply)
        else $error("supply low not flagged");

    property p_turns_keep;
        @(posedge clock) disable iff (!rst_n)
        (caution_q[0] && !(special_go && special_cmd == diag_pkg::SPECIAL_TURNS_RESET))
            |=> caution_q[0];
    endproperty
    a_turns_keep: assert property (p_turns_keep)
        else $error("turns overflow cleared wrongly");

    property p_temp_range;
        @(posedge clock) disable iff (!rst_n)
        ##1 ($signed(die_temperature_q) >= diag_pkg::TEMP_MIN
            && $signed(die_temperature_q) <= diag_pkg::TEMP_MAX);
    endproperty
    a_temp_range: assert property (p_temp_range)
        else $error("temperature beyond saturation");

    property p_temp_flag;
        @(posedge clock) disable iff (!rst_n)
        (temp_raw > 13'(diag_pkg::TEMP_MAX) || temp_raw < 13'(diag_pkg::TEMP_MIN))
            |=> caution_q[diag_pkg::CAU_TEMP_BIT];
    endproperty
    a_temp_flag: assert property (p_temp_flag)
        else $error("temperature range flag missing");

    property p_tag;
        @(posedge clock) disable iff (!rst_n)
        (reg_read && !reg_write && reg_addr == diag_pkg::CAUTION_OFFSET)
            |=> read_valid_q && read_data_q[15:12] == diag_pkg::CAUTION_TAG;
    endproperty
    a_tag: assert property (p_tag)
        else $error("caution tag wrong");

    property p_summary;
        @(posedge clock) disable iff (!rst_n)
        ##1 (|(caution_q & ~flag_mask[11:0])) |=> any_fault_flag_q;
    endproperty
    a_summary: assert property (p_summary)
        else $error("fault flag missing");

    property p_field_tick;
        @(posedge clock) disable iff (!rst_n)
        field_tick_q |=> !field_tick_q;
    endproperty
    a_field_tick: assert property (p_field_tick)
        else $error("refresh tick too long");
endmodule : diag_regs
`default_nettype wire

// >>> tb/diag_host.sv
/*
 Host model: reads, writes and clear strobes on the register port.
 Assumes the bank samples its inputs on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module diag_host (
    // Clock
    input wire logic clock,
    // Register port
    output var logic [7:0] reg_addr,
    output var logic reg_read,
    output var logic reg_write,
    output var logic error_clear,
    output var logic caution_clear,
    output var logic [5:0] special_cmd,
    output var logic special_go,
    input wire logic [15:0] read_data_q,
    input wire logic read_valid_q
);
    initial begin
        {reg_addr, reg_read, reg_write, error_clear, caution_clear} = 12'h000;
        {special_cmd, special_go} = 7'h00;
    end
    // Strobe order {write, error clear, caution clear, special}
    task automatic strobe(input logic [3:0] sel, input logic [7:0] addr, input logic [5:0] cmd);
        @(negedge clock);
        reg_addr = addr;
        special_cmd = cmd;
        {reg_write, error_clear, caution_clear, special_go} = sel;
        @(negedge clock);
        {reg_write, error_clear, caution_clear, special_go} = 4'h0;
    endtask : strobe
    task automatic read(input logic [7:0] addr, input logic wr, output logic [15:0] data,
                        output logic ok);
        @(negedge clock);
        reg_addr = addr;
        reg_read = 1'b1;
        reg_write = wr;
        @(negedge clock);
        {reg_read, reg_write} = 2'h0;
        ok = 1'b0;
        data = 16'h0000;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (read_valid_q === 1'b1) begin
                data = read_data_q;
                ok = 1'b1;
            end else begin
                @(negedge clock);
            end
        end
    endtask : read
endmodule : diag_host
`default_nettype wire

// >>> tb/tb_diag_regs.sv
/*
 Testbench for the diagnostic register bank, driven through a host model.
 Assumes diag_pkg, diag_regs and diag_host are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_diag_regs;
    logic clock, rst_n, reg_read, reg_write, error_clear, caution_clear, special_go;
    logic [7:0] reg_addr;
    logic [5:0] special_cmd;
    logic [15:0] read_data_q, flag_mask;
    logic read_valid_q, asupply_low_pin, low_power_state, awake_sample, eighth_turns;
    diag_pkg::event_type events;
    logic [11:0] field_gauss, awake_angle, die_temperature_q;
    logic signed [12:0] temp_raw, turns_raw;
    logic any_fault_flag_q;
    int err_count = 0;
    int cmp_count = 0;

    diag_regs #(.FIELD_PERIOD(16)) u_dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_read(reg_read),
        .reg_write(reg_write), .error_clear(error_clear), .caution_clear(caution_clear),
        .special_cmd(special_cmd), .special_go(special_go), .read_data_q(read_data_q),
        .read_valid_q(read_valid_q), .asupply_low_pin(asupply_low_pin), .events(events),
        .field_gauss(field_gauss), .weak_field_limit(12'h0C8), .strong_field_limit(12'h4B0),
        .temp_raw(temp_raw), .low_power_state(low_power_state), .awake_sample(awake_sample),
        .awake_angle(awake_angle), .eighth_turns(eighth_turns), .turns_raw(turns_raw),
        .flag_mask(flag_mask), .any_fault_flag_q(any_fault_flag_q),
        .die_temperature_q(die_temperature_q));
    diag_host u_host (
        .clock(clock), .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
        .error_clear(error_clear), .caution_clear(caution_clear), .special_cmd(special_cmd),
        .special_go(special_go), .read_data_q(read_data_q), .read_valid_q(read_valid_q));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        u_host.read(addr, 1'b0, d, ok);
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch t=%0t read not answered", $time);
            wrap_up();
        end else begin
            check(d, exp);
        end
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask : wt
    task automatic ev(input logic [7:0] v);
        @(negedge clock);
        events = diag_pkg::event_type'(v);
        @(negedge clock);
        events = '0;
        wt(2);
    endtask : ev
    task automatic wake(input logic [11:0] a);
        @(negedge clock);
        awake_angle = a;
        awake_sample = 1'b1;
        @(negedge clock);
        awake_sample = 1'b0;
        wt(2);
    endtask : wake
    task automatic clr;
        u_host.strobe(4'h6, 8'h00, 6'h00);
    endtask : clr
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_events;
        int pos [7] = '{11, 10, 8, 7, 5, 4, 2};
        logic [15:0] want;
        for (int k = 0; k < 7; k++) begin
            ev(8'h40 >> k);
            want = 16'hB000 | (16'h0001 << pos[k]);
            rd(8'h26, want);
            wt(4);
            rd(8'h26, want);
            check({15'h0000, any_fault_flag_q}, 16'h0001);
            clr();
            rd(8'h26, 16'hB000);
        end
    endtask : t_events
    task automatic t_summary;
        ev(8'h02);
        rd(8'h24, 16'hA800);
        flag_mask = 16'h0FFF;
        wt(3);
        rd(8'h24, 16'hA000);
        check({15'h0000, any_fault_flag_q}, 16'h0000);
        flag_mask = 16'h0000;
        clr();
    endtask : t_summary
    task automatic t_supply;
        asupply_low_pin = 1'b1;
        wt(6);
        clr();
        rd(8'h24, 16'hA004);
        check({15'h0000, any_fault_flag_q}, 16'h0001);
        flag_mask = 16'h7000;
        wt(2);
        check({15'h0000, any_fault_flag_q}, 16'h0000);
        flag_mask = 16'h0000;
        asupply_low_pin = 1'b0;
        wt(6);
        clr();
        rd(8'h24, 16'hA000);
    endtask : t_supply
    task automatic t_field;
        field_gauss = 12'h5DC;
        wt(40);
        rd(8'h2A, 16'hE5DC);
        rd(8'h26, 16'hB002);
        field_gauss = 12'h064;
        wt(40);
        rd(8'h24, 16'hA802);
        rd(8'h2A, 16'hE064);
        field_gauss = 12'h1F4;
        wt(40);
        clr();
        rd(8'h24, 16'hA000);
    endtask : t_field
    task automatic tcase(input logic [12:0] raw, input logic [15:0] et, input logic [15:0] ec);
        temp_raw = raw;
        wt(4);
        rd(8'h28, et);
        check({4'hF, die_temperature_q}, et);
        rd(8'h26, ec);
        temp_raw = 13'h0000;
        wt(2);
        clr();
    endtask : tcase
    task automatic t_turns;
        turns_raw = 13'h0200;
        wt(3);
        turns_raw = 13'h0000;
        clr();
        rd(8'h26, 16'hB001);
        u_host.strobe(4'h1, 8'h00, 6'h1D);
        rd(8'h26, 16'hB001);
        u_host.strobe(4'h1, 8'h00, 6'h1E);
        rd(8'h26, 16'hB000);
        eighth_turns = 1'b1;
        turns_raw = 13'h17FF;
        wt(3);
        turns_raw = 13'h0000;
        rd(8'h26, 16'hB001);
        u_host.strobe(4'h1, 8'h00, 6'h1E);
        rd(8'h26, 16'hB000);
    endtask : t_turns
    task automatic t_sleep;
        low_power_state = 1'b1;
        wake(12'h000);
        wake(12'h3E8);
        rd(8'h26, 16'hB000);
        wake(12'hBB8);
        rd(8'h26, 16'hB008);
        low_power_state = 1'b0;
        clr();
    endtask : t_sleep
    task automatic t_write;
        logic [15:0] d;
        logic ok;
        ev(8'h02);
        u_host.strobe(4'h8, 8'h26, 6'h00);
        rd(8'h26, 16'hB010);
        rd(8'h30, 16'h0000);
        u_host.read(8'h26, 1'b1, d, ok);
        check({15'h0000, ok}, 16'h0000);
        clr();
    endtask : t_write

    initial begin
        rst_n = 1'b0;
        {asupply_low_pin, low_power_state, awake_sample, eighth_turns} = 4'h0;
        events = '0;
        field_gauss = 12'h1F4;
        {temp_raw, turns_raw} = 26'h0000000;
        awake_angle = 12'h000;
        flag_mask = 16'h0000;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        rd(8'h24, 16'hA001);
        clr();
        rd(8'h24, 16'hA000);
        t_events();
        t_summary();
        t_supply();
        t_field();
        tcase(13'h0064, 16'hF064, 16'hB000);
        tcase(13'h07D0, 16'hF4D8, 16'hB040);
        tcase(13'h1C18, 16'hFD58, 16'hB040);
        tcase(13'h04D8, 16'hF4D8, 16'hB000);
        t_turns();
        t_sleep();
        t_write();
        rst_n = 1'b0;
        wt(2);
        rst_n = 1'b1;
        rd(8'h24, 16'hA001);
        wrap_up();
    end
endmodule : tb_diag_regs
`default_nettype wire
